// [hw/mgmt_regs.svh]
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH

// ****************************************************************
// clock and timing figures
// ****************************************************************
`define CLK_MHZ        100
`define T_INIT_MS      2000
`define T_RST_MIN_US   10
`define CYC_PER_MS     (`CLK_MHZ * 1000)
`define CYC_PER_US     `CLK_MHZ

// ****************************************************************
// serial bus identity and byte map
// ****************************************************************
`define DEV_ADDR_DEF   7'h50
`define SB_STATUS      8'h02
`define SB_FLAGS       8'h03
`define SB_MASK        8'h04
`define SB_CTRL        8'h05

// ****************************************************************
// field positions
// ****************************************************************
`define ST_DNR_BIT     0
`define ST_LOS_BIT     1
`define ST_LPOW_BIT    2
`define ST_LASER_BIT   3
`define ST_READY_BIT   4
`define FLG_READY      0
`define FLG_LOS        1
`define FLG_TXF        2
`define FLG_AUX        3
`define CTRL_PDOWN_BIT 0
`define FLAG_W         4

// ****************************************************************
// register bus offsets and reset values
// ****************************************************************
`define AR_STATUS      8'h00
`define AR_FLAGS       8'h04
`define AR_MASK        8'h08
`define AR_CTRL        8'h0c
`define MASK_RST       4'h0
`define CTRL_RST       8'h00

`endif

// [hw/mgmt_pkg.sv]
package mgmt_pkg;

	// ****************************************************************
	// pin group that crosses into the clk_sys domain
	// ****************************************************************
	typedef struct packed {
		logic module_reset_n;
		logic low_power_request;
		logic module_select_n;
		logic transmit_disable;
		logic scl;
		logic sda;
		logic los;
		logic tx_fault;
		logic aux_alarm;
	} pins_t;

	// ****************************************************************
	// serial bus slave states, one-hot
	// ****************************************************************
	typedef enum logic [4:0] {
		SB_IDLE  = 5'b00001,
		SB_RX    = 5'b00010,
		SB_ACK   = 5'b00100,
		SB_TX    = 5'b01000,
		SB_TXACK = 5'b10000
	} sb_state_t;

endpackage : mgmt_pkg

// [hw/module_mgmt_control_status.sv]
// Summary of operation
// - after power-on or reset release, reach full function within 2000 ms
// - a module reset low longer than the minimum pulse is a reset
// - serial bus answers no later than 2000 ms after power valid
// - within 2000 ms clear data-not-ready bit and assert interrupt
// - after module reset rises, full function again within 2000 ms
// - low-power request high lowers power within 100 us
// - interrupt output goes low within 200 ms of its cause
// - host read clears flags; interrupt releases within 500 us
// - loss of signal sets its bit and interrupt within 100 ms
// - other conditions set their flag and interrupt within 200 ms
// - setting a mask bit stops that flag's interrupt within 100 ms
// - clearing a mask bit resumes that flag's interrupt within 100 ms
// - module select low makes serial bus answer within 100 us
// - module select high stops serial bus answers within 100 us
// - power-down bit set lowers power within 100 ms
// - power-down bit cleared gives full function within 300 ms
// - full function means interrupt asserted by data-not-ready clearing
// - clear-on-read counts from read stop; mask, power-down from write
// - transmit disable high or open turns laser off, low turns it on
`timescale 1ns/1ps
`include "mgmt_regs.svh"

module module_mgmt_control_status #(
	parameter int unsigned INIT_CYC = `T_INIT_MS * `CYC_PER_MS,
	parameter logic [6:0]  DEV_ADDR = `DEV_ADDR_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        module_reset_n,
	input  wire logic        low_power_request,
	input  wire logic        module_select_n,
	input  wire logic        transmit_disable,
	input  wire logic        scl,
	input  wire logic        sda_i,
	input  wire logic        los_in,
	input  wire logic        tx_fault_in,
	input  wire logic        aux_alarm_in,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             int_n,
	output logic             module_present_n,
	output logic             laser_enable,
	output logic             power_low
);

	localparam int unsigned RST_MIN_CYC = `T_RST_MIN_US * `CYC_PER_US;

	// pin levels held during reset; conditions idle low so that the
	// edge detectors see no false rising edge when reset lets go
	localparam mgmt_pkg::pins_t PINS_IDLE = '{
		module_reset_n:    1'b1,
		low_power_request: 1'b1,
		module_select_n:   1'b1,
		transmit_disable:  1'b1,
		scl:               1'b1,
		sda:               1'b1,
		los:               1'b0,
		tx_fault:          1'b0,
		aux_alarm:         1'b0
	};

	// ****************************************************************
	// declarations
	// ****************************************************************
	mgmt_pkg::pins_t     pins_in;
	mgmt_pkg::pins_t     sync1_r;
	mgmt_pkg::pins_t     sync2_r;
	mgmt_pkg::pins_t     sync3_r;
	mgmt_pkg::sb_state_t sb_state_r;
	logic [15:0]         rst_cnt_r;
	logic                mreset_r;
	logic                soft_rst;
	logic [31:0]         init_cnt_r;
	logic                init_done_r;
	logic                dnr_r;
	logic                dnr_q_r;
	logic [`FLAG_W-1:0]  cond_q_r;
	logic [`FLAG_W-1:0]  flag_set;
	logic [`FLAG_W-1:0]  flags_r;
	logic [`FLAG_W-1:0]  mask_r;
	logic [7:0]          ctrl_r;
	logic                clr_pend_r;
	logic                clr_now;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_det;
	logic                stop_det;
	logic                selected;
	logic [3:0]          bit_cnt_r;
	logic [7:0]          shreg_r;
	logic [7:0]          ptr_r;
	logic                is_addr_r;
	logic                is_rd_r;
	logic                ptr_set_r;
	logic                sb_wr_r;
	logic [7:0]          sb_wptr_r;
	logic [7:0]          sb_wdata_r;
	logic                ah_wr_r;
	logic [7:0]          ah_addr_r;
	logic [7:0]          rd_byte;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// status byte, shared by both read paths
	function automatic logic [7:0] status_byte();
		logic [7:0] s;
		s = 8'h00;
		s[`ST_DNR_BIT]   = dnr_r;
		s[`ST_LOS_BIT]   = sync2_r.los;
		s[`ST_LPOW_BIT]  = power_low;
		s[`ST_LASER_BIT] = laser_enable;
		s[`ST_READY_BIT] = init_done_r;
		return s;
	endfunction : status_byte

	// byte view of the map, addressed by serial pointer or bus offset
	function automatic logic [7:0] map_read(input logic [7:0] a,
		input logic ahb);
		logic [7:0] d;
		d = 8'h00;
		if (ahb) begin
			case (a)
				`AR_STATUS: d = status_byte();
				`AR_FLAGS:  d = {4'h0, flags_r};
				`AR_MASK:   d = {4'h0, mask_r};
				`AR_CTRL:   d = ctrl_r;
				default:    d = 8'h00;
			endcase
		end else begin
			case (a)
				`SB_STATUS: d = status_byte();
				`SB_FLAGS:  d = {4'h0, flags_r};
				`SB_MASK:   d = {4'h0, mask_r};
				`SB_CTRL:   d = ctrl_r;
				default:    d = 8'h00;
			endcase
		end
		return d;
	endfunction : map_read

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	assign pins_in = '{module_reset_n, low_power_request, module_select_n,
		transmit_disable, scl, sda_i, los_in, tx_fault_in, aux_alarm_in};

	// two stages for every outside pin; third stage only feeds edges
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_r <= PINS_IDLE;
			sync2_r <= PINS_IDLE;
			sync3_r <= PINS_IDLE;
		end else begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	assign scl_rise  = sync2_r.scl & ~sync3_r.scl;
	assign scl_fall  = ~sync2_r.scl & sync3_r.scl;
	assign start_det = sync2_r.scl & sync3_r.scl & ~sync2_r.sda & sync3_r.sda;
	assign stop_det  = sync2_r.scl & sync3_r.scl & sync2_r.sda & ~sync3_r.sda;

	// ****************************************************************
	// module reset filter and initialisation
	// ****************************************************************
	// short glitches on the pin are ignored; only a long low resets
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rst_cnt_r <= 16'h0000;
			mreset_r  <= 1'b0;
		end else if (sync2_r.module_reset_n) begin
			rst_cnt_r <= 16'h0000;
			mreset_r  <= 1'b0;
		end else if (rst_cnt_r >= 16'(RST_MIN_CYC - 1)) begin
			mreset_r  <= 1'b1;
		end else begin
			rst_cnt_r <= rst_cnt_r + 16'h0001;
		end
	end

	assign soft_rst = !rst_n || mreset_r;

	// init timer restarts on power-on and on every module reset
	always_ff @(posedge clk_sys) begin
		if (soft_rst) begin
			init_cnt_r  <= 32'h0000_0000;
			init_done_r <= 1'b0;
		end else if (!init_done_r) begin
			if (init_cnt_r >= INIT_CYC - 1)
				init_done_r <= 1'b1;
			else
				init_cnt_r <= init_cnt_r + 32'h0000_0001;
		end
	end

	// data not ready while initialising or powered down
	always_ff @(posedge clk_sys) begin
		if (soft_rst) begin
			dnr_r   <= 1'b1;
			dnr_q_r <= 1'b1;
		end else begin
			dnr_r   <= !init_done_r || ctrl_r[`CTRL_PDOWN_BIT];
			dnr_q_r <= dnr_r;
		end
	end

	// ****************************************************************
	// flags and interrupt
	// ****************************************************************
	// rising edge of each condition sets its sticky flag
	always_ff @(posedge clk_sys) begin
		if (soft_rst)
			cond_q_r <= '0;
		else
			cond_q_r <= {sync2_r.aux_alarm, sync2_r.tx_fault,
				sync2_r.los, 1'b0};
	end

	always_comb begin
		flag_set = {sync2_r.aux_alarm, sync2_r.tx_fault, sync2_r.los, 1'b0}
			& ~cond_q_r;
		flag_set[`FLG_READY] = dnr_q_r & ~dnr_r;
	end

	assign clr_now = clr_pend_r & stop_det;

	// a set in the cycle of the clear wins, so no event is lost
	always_ff @(posedge clk_sys) begin
		if (soft_rst)
			flags_r <= '0;
		else
			flags_r <= (flags_r & ~{`FLAG_W{clr_now}}) | flag_set;
	end

	// low while any unmasked flag stays set; mask acts in one cycle
	always_ff @(posedge clk_sys) begin
		if (soft_rst)
			int_n <= 1'b1;
		else
			int_n <= ~|(flags_r & ~mask_r);
	end

	// ****************************************************************
	// power, laser and presence
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			power_low        <= 1'b1;
			laser_enable     <= 1'b0;
			module_present_n <= 1'b0;
		end else begin
			power_low        <= sync2_r.low_power_request
				| ctrl_r[`CTRL_PDOWN_BIT];
			laser_enable     <= ~sync2_r.transmit_disable;
			module_present_n <= 1'b0;
		end
	end

	// ****************************************************************
	// control registers, written from the serial bus or the AHB side
	// ****************************************************************
	// serial writes take effect once the byte is acknowledged
	always_ff @(posedge clk_sys) begin
		if (soft_rst) begin
			mask_r <= `MASK_RST;
			ctrl_r <= `CTRL_RST;
		end else if (sb_wr_r) begin
			if (sb_wptr_r == `SB_MASK)
				mask_r <= sb_wdata_r[`FLAG_W-1:0];
			if (sb_wptr_r == `SB_CTRL)
				ctrl_r <= sb_wdata_r;
		end else if (ah_wr_r) begin
			if (ah_addr_r == `AR_MASK)
				mask_r <= hwdata[`FLAG_W-1:0];
			if (ah_addr_r == `AR_CTRL)
				ctrl_r <= hwdata[7:0];
		end
	end

	// ****************************************************************
	// AHB-Lite slave, zero wait states
	// ****************************************************************
	// read data is built in the address phase so it stands in the data phase
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			ah_wr_r   <= 1'b0;
			ah_addr_r <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			ah_wr_r   <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				ah_addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
				ah_wr_r   <= hwrite;
				if (!hwrite && haddr[31:8] == 24'h00_0000)
					hrdata <= {24'h00_0000, map_read(haddr[7:0], 1'b1)};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// 2-wire serial slave
	// ****************************************************************
	assign selected = init_done_r && !sync2_r.module_select_n;

	// byte at the serial pointer, loaded when a read byte starts
	assign rd_byte = map_read(ptr_r, 1'b0);

	// deselect aborts at once and lets go of the data line
	always_ff @(posedge clk_sys) begin
		if (soft_rst || !selected) begin
			sb_state_r <= mgmt_pkg::SB_IDLE;
			sda_oe     <= 1'b0;
			sda_o      <= 1'b0;
			bit_cnt_r  <= 4'h0;
			shreg_r    <= 8'h00;
			ptr_r      <= 8'h00;
			is_addr_r  <= 1'b0;
			is_rd_r    <= 1'b0;
			ptr_set_r  <= 1'b0;
			clr_pend_r <= 1'b0;
			sb_wr_r    <= 1'b0;
			sb_wptr_r  <= 8'h00;
			sb_wdata_r <= 8'h00;
		end else begin
			sb_wr_r <= 1'b0;
			sda_o   <= 1'b0;
			if (stop_det) begin
				sb_state_r <= mgmt_pkg::SB_IDLE;
				sda_oe     <= 1'b0;
				clr_pend_r <= 1'b0; // flags clear on this stop
			end else if (start_det) begin
				sb_state_r <= mgmt_pkg::SB_RX;
				sda_oe     <= 1'b0;
				bit_cnt_r  <= 4'h0;
				is_addr_r  <= 1'b1;
				ptr_set_r  <= 1'b0;
			end else begin
				case (sb_state_r)
					mgmt_pkg::SB_IDLE: begin
						sda_oe <= 1'b0;
					end
					mgmt_pkg::SB_RX: begin
						if (scl_rise && bit_cnt_r != 4'h8) begin
							shreg_r   <= {shreg_r[6:0], sync2_r.sda};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == 4'h8) begin
							if (is_addr_r) begin
								if (shreg_r[7:1] == DEV_ADDR) begin
									is_rd_r    <= shreg_r[0];
									sda_oe     <= 1'b1;
									sb_state_r <= mgmt_pkg::SB_ACK;
								end else begin
									sb_state_r <= mgmt_pkg::SB_IDLE;
								end
								is_addr_r <= 1'b0;
							end else begin
								if (!ptr_set_r) begin
									ptr_r     <= shreg_r;
									ptr_set_r <= 1'b1;
								end else begin
									sb_wr_r    <= 1'b1;
									sb_wptr_r  <= ptr_r;
									sb_wdata_r <= shreg_r;
									ptr_r      <= ptr_r + 8'h01;
								end
								sda_oe     <= 1'b1;
								sb_state_r <= mgmt_pkg::SB_ACK;
							end
						end
					end
					mgmt_pkg::SB_ACK: begin
						if (scl_fall) begin
							if (is_rd_r) begin
								shreg_r    <= rd_byte;
								sda_oe     <= ~rd_byte[7];
								if (ptr_r == `SB_FLAGS)
									clr_pend_r <= 1'b1;
								ptr_r      <= ptr_r + 8'h01;
								bit_cnt_r  <= 4'h1;
								sb_state_r <= mgmt_pkg::SB_TX;
							end else begin
								sda_oe     <= 1'b0;
								bit_cnt_r  <= 4'h0;
								sb_state_r <= mgmt_pkg::SB_RX;
							end
						end
					end
					mgmt_pkg::SB_TX: begin
						if (scl_fall) begin
							if (bit_cnt_r == 4'h8) begin
								sda_oe     <= 1'b0;
								sb_state_r <= mgmt_pkg::SB_TXACK;
							end else begin
								sda_oe    <= ~shreg_r[6];
								shreg_r   <= {shreg_r[6:0], 1'b0};
								bit_cnt_r <= bit_cnt_r + 4'h1;
							end
						end
					end
					mgmt_pkg::SB_TXACK: begin
						if (scl_rise) begin
							if (sync2_r.sda)
								sb_state_r <= mgmt_pkg::SB_IDLE;
							else
								sb_state_r <= mgmt_pkg::SB_ACK;
						end
					end
					default: begin
						sb_state_r <= mgmt_pkg::SB_IDLE;
						sda_oe     <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule : module_mgmt_control_status

// [testbench/mgmt_checker_properties.sv]
`timescale 1ns/1ps
`include "mgmt_regs.svh"
module mgmt_checker #(
	parameter int unsigned INIT_CYC = 200
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        module_reset_n,
	input wire logic        low_power_request,
	input wire logic        module_select_n,
	input wire logic        transmit_disable,
	input wire logic        los_in,
	input wire logic        tx_fault_in,
	input wire logic        sda_oe,
	input wire logic        int_n,
	input wire logic        laser_enable,
	input wire logic        power_low
);
	// **********
	// helper state
	// **********
	logic [31:0] up_r;
	logic [10:0] low_r;
	logic [7:0]  wa_r;
	logic        wp_r;
	logic [3:0]  mask_r;
	logic        pd_r;

	// init age; a recognised module reset starts it again
	always_ff @(posedge clk_sys) begin
		if (!rst_n || low_r >= 11'h3e8)
			up_r <= 32'h0;
		else if (up_r <= INIT_CYC + 20)
			up_r <= up_r + 32'h1;
	end

	// cycles the module reset pin has been held low
	always_ff @(posedge clk_sys) begin
		if (!rst_n || module_reset_n)
			low_r <= 11'h0;
		else if (low_r != 11'h7ff)
			low_r <= low_r + 11'h1;
	end

	// mask and power-down seen on the register bus only
	always_ff @(posedge clk_sys) begin
		if (!rst_n || low_r >= 11'h3e8) begin
			wp_r   <= 1'h0;
			mask_r <= 4'h0;
			pd_r   <= 1'h0;
		end else begin
			wp_r <= hsel && htrans[1] && hready && hwrite;
			wa_r <= haddr[7:0];
			if (wp_r && wa_r == `AR_MASK)
				mask_r <= hwdata[3:0];
			if (wp_r && wa_r == `AR_CTRL)
				pd_r <= hwdata[0];
		end
	end

	// **********
	// properties
	// **********
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	chk_init_int: assert property (up_r == INIT_CYC + 20 |-> !int_n)
		else $error("interrupt missing after init");
	chk_modrst_quiet: assert property (low_r > 11'h3f2 |-> int_n && !sda_oe)
		else $error("held module reset not obeyed");
	chk_lp_power: assert property (low_power_request [*6] |-> power_low)
		else $error("low power request ignored");
	chk_pdown_power: assert property ($rose(pd_r) |-> ##[0:3] power_low)
		else $error("power-down bit ignored");
	chk_los_int: assert property ($rose(los_in) && up_r > INIT_CYC + 20
		&& !mask_r[1] |-> ##[1:8] !int_n)
		else $error("loss of signal gave no interrupt");
	chk_fault_int: assert property ($rose(tx_fault_in) && up_r > INIT_CYC + 20
		&& !mask_r[2] |-> ##[1:8] !int_n)
		else $error("transmit fault gave no interrupt");
	chk_desel_idle: assert property (module_select_n [*8] |-> !sda_oe)
		else $error("serial bus driven while deselected");
	chk_laser_off: assert property (transmit_disable [*6] |-> !laser_enable)
		else $error("laser on while disabled");

	// main scenarios reached
	cover property ($fell(int_n));
	cover property ($rose(sda_oe));
	cover property ($rose(power_low));
endmodule : mgmt_checker

bind module_mgmt_control_status mgmt_checker #(.INIT_CYC(INIT_CYC)) u_chk (
	.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.module_reset_n, .low_power_request, .module_select_n,
	.transmit_disable, .los_in, .tx_fault_in, .sda_oe, .int_n,
	.laser_enable, .power_low
);

// [testbench/host_link_model.sv]
`timescale 1ns/1ps
`include "mgmt_regs.svh"
module host_link_model (
	output logic      scl,
	output logic      sda_line,
	input  wire logic sda_oe
);
	logic pull_r;

	// open drain: either side pulling wins, pull-up otherwise
	assign sda_line = !(pull_r || sda_oe);

	// clock stands high between frames
	initial begin
		scl = 1'h1;
		pull_r = 1'h0;
	end

	// 125 ns bit: data set mid-low, sampled mid-high
	task automatic put_bit(input logic b, output logic s);
		#31.25 pull_r = !b;
		#31.25 scl = 1'h1;
		#31.25 s = sda_line;
		#31.25 scl = 1'h0;
	endtask : put_bit

	// also serves as repeated start
	task automatic start_cond();
		#31.25 pull_r = 1'h0;
		#31.25 scl = 1'h1;
		#31.25 pull_r = 1'h1;
		#31.25 scl = 1'h0;
	endtask : start_cond

	// clear-on-read and write timing count from here
	task automatic stop_cond();
		#31.25 pull_r = 1'h1;
		#31.25 scl = 1'h1;
		#31.25 pull_r = 1'h0;
		#31.25;
	endtask : stop_cond

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], s);
		put_bit(1'h1, ack);
	endtask : put_byte

	// ack low means the address was taken
	task automatic xfer_wr(input logic [7:0] p, input logic [7:0] d,
		output logic ack);
		logic a1;
		start_cond();
		put_byte({`DEV_ADDR_DEF, 1'h0}, ack);
		if (!ack) begin
			put_byte(p, a1);
			put_byte(d, a1);
		end
		stop_cond();
	endtask : xfer_wr

	task automatic xfer_rd(input logic [7:0] p, output logic [7:0] d,
		output logic ack);
		logic s;
		d = 8'h0;
		start_cond();
		put_byte({`DEV_ADDR_DEF, 1'h0}, ack);
		if (!ack) begin
			put_byte(p, s);
			start_cond();
			put_byte({`DEV_ADDR_DEF, 1'h1}, s);
			for (int i = 7; i >= 0; i--)
				put_bit(1'h1, d[i]);
			put_bit(1'h1, s); // nack ends the read
		end
		stop_cond();
	endtask : xfer_rd
endmodule : host_link_model

// [testbench/module_mgmt_control_status_tb.sv]
`timescale 1ns/1ps
`include "mgmt_regs.svh"
module module_mgmt_control_status_tb;
	localparam int unsigned INIT = 200;
	logic        clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic        module_reset_n, low_power_request, module_select_n;
	logic        transmit_disable, scl, sda_i, sda_o, sda_oe, int_n;
	logic        module_present_n, laser_enable, power_low, a_q;
	logic [1:0]  htrans;
	logic [2:0]  hsize, cond_r;
	logic [7:0]  d_q;
	logic [31:0] haddr, hwdata, hrdata, q;
	int          seed, errors, cmp_count, mask_m, ctrl_m, flags_m;

	assign hready = hreadyout;

	module_mgmt_control_status #(.INIT_CYC(INIT)) u_dut (
		.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .module_reset_n,
		.low_power_request, .module_select_n, .transmit_disable, .scl,
		.sda_i, .los_in(cond_r[0]), .tx_fault_in(cond_r[1]),
		.aux_alarm_in(cond_r[2]), .sda_o, .sda_oe, .int_n,
		.module_present_n, .laser_enable, .power_low
	);
	host_link_model u_host (.scl, .sda_line(sda_i), .sda_oe);

	// 100 MHz system clock
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	// a hang counts as a mismatch
	initial begin
		#400000;
		errors++;
		wrap_up();
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// single word transfer; q holds the read data
	task automatic ahb(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do
			@(posedge clk_sys);
		while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge clk_sys);
		while (hready !== 1'h1);
		q = hrdata;
	endtask : ahb

	// bounded wait, the caller compares
	task automatic wait_int(input int lim);
		for (int n = 0; n < lim && int_n !== 1'h0; n++)
			@(posedge clk_sys);
	endtask : wait_int

	// serial read of the flags byte, which clears them
	task automatic rd_flags();
		u_host.xfer_rd(`SB_FLAGS, d_q, a_q);
		check(a_q, 1'h0);
		check(d_q, flags_m);
		flags_m = 0;
		cyc(10);
		check(int_n, 1'h1);
		ahb(`AR_FLAGS, 1'h0, 32'h0);
		check(q, 32'h0);
	endtask : rd_flags

	initial begin
		seed = 41;
		errors = 0;
		cmp_count = 0;
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		{rst_n, low_power_request, module_select_n, cond_r} = '0;
		hsize = 3'h2;
		module_reset_n = 1'h1;
		transmit_disable = 1'h1;
		cyc(12);
		rst_n <= 1'h1;
		cyc(1);
		ahb(`AR_STATUS, 1'h0, 32'h0);
		check(q[0], 1'h1);
		check({hresp, sda_o, module_present_n, hreadyout}, 4'h1);
		ahb(32'h10, 1'h0, 32'h0);
		check(q, 32'h0);
		wait_int(INIT + 100);
		check(int_n, 1'h0);
		ahb(`AR_STATUS, 1'h0, 32'h0);
		check(q, 32'h10);
		flags_m = 1;
		rd_flags();
		$display("init test done");
		// each condition alone, unmasked
		for (int i = 1; i < 4; i++) begin
			cond_r <= 3'h1 << (i - 1);
			cyc(8);
			check(int_n, 1'h0);
			flags_m = 1 << i;
			ahb(`AR_FLAGS, 1'h0, 32'h0);
			check(q, flags_m);
			ahb(`AR_STATUS, 1'h0, 32'h0);
			check(q[1], i == 1);
			rd_flags();
			cond_r <= 3'h0;
			cyc(4);
		end
		$display("flag test done");
		mask_m = ($random(seed) & 32'h6) | 32'h8;
		ahb(`AR_MASK, 1'h1, mask_m);
		ahb(`AR_MASK, 1'h0, 32'h0);
		check(q, mask_m);
		cond_r <= 3'h4;
		cyc(8);
		check(int_n, 1'h1);
		mask_m = mask_m & 32'h7;
		ahb(`AR_MASK, 1'h1, mask_m);
		cyc(3);
		check(int_n, 1'h0);
		flags_m = 8;
		rd_flags();
		cond_r <= 3'h0;
		$display("mask test done");
		low_power_request <= 1'h1;
		cyc(8);
		check(power_low, 1'h1);
		low_power_request <= 1'h0;
		cyc(8);
		check(power_low, 1'h0);
		ctrl_m = $random(seed) | 32'h1;
		ahb(`AR_CTRL, 1'h1, ctrl_m);
		cyc(3);
		check(power_low, 1'h1);
		ahb(`AR_CTRL, 1'h0, 32'h0);
		check(q, ctrl_m & 32'hff);
		ctrl_m = $random(seed) & 32'hfe;
		u_host.xfer_wr(`SB_CTRL, ctrl_m[7:0], a_q);
		check(a_q, 1'h0);
		cyc(4);
		check(power_low, 1'h0);
		check(int_n, 1'h0);
		ahb(`AR_CTRL, 1'h0, 32'h0);
		check(q, ctrl_m & 32'hff);
		flags_m = 1;
		rd_flags();
		$display("power test done");
		transmit_disable <= 1'h0;
		cyc(6);
		check(laser_enable, 1'h1);
		ahb(`AR_STATUS, 1'h0, 32'h0);
		check(q, 32'h18);
		transmit_disable <= 1'h1;
		cyc(6);
		check(laser_enable, 1'h0);
		module_select_n <= 1'h1;
		cyc(20);
		u_host.xfer_rd(`SB_STATUS, d_q, a_q);
		check(a_q, 1'h1);
		cyc(1);
		module_select_n <= 1'h0;
		cyc(20);
		u_host.xfer_rd(`SB_STATUS, d_q, a_q);
		check(a_q, 1'h0);
		check(d_q, 8'h10);
		cyc(1);
		$display("pin test done");
		mask_m = ($random(seed) & 32'he) | 32'h2;
		ahb(`AR_MASK, 1'h1, mask_m);
		module_reset_n <= 1'h0;
		cyc(100);
		module_reset_n <= 1'h1;
		cyc(10);
		ahb(`AR_MASK, 1'h0, 32'h0);
		check(q, mask_m);
		module_reset_n <= 1'h0;
		cyc(1100);
		check(int_n, 1'h1);
		ahb(`AR_STATUS, 1'h0, 32'h0);
		check(q, 32'h1);
		module_reset_n <= 1'h1;
		cyc(4);
		ahb(`AR_MASK, 1'h0, 32'h0);
		check(q, 32'h0);
		wait_int(INIT + 100);
		check(int_n, 1'h0);
		flags_m = 1;
		rd_flags();
		$display("module reset test done");
		wrap_up();
	end
endmodule : module_mgmt_control_status_tb
